/* src/osc_ctrl_pkg.sv */
// Functional notes
// - Unlock needs E7 then 18, back to back
// - Relock after one accepted control write
// - Bit 7 enables internal oscillator, resets 1
// - Bit 6 crystal; claims both port pins
// - Bit 5 enables watchdog oscillator, resets 1
// - Bit 4 system clock failure detect/recovery
// - Low field selects system clock source
// - No clocks, no system clock failure detection: halt until power-on
`default_nettype none
package osc_ctrl_pkg;
    // Register indices; byte address is four times the index
    localparam int APB_ADDR_W = 14;
    localparam logic [11:0] CTRL_IDX = 12'hf86;
    localparam logic [11:0] STATUS_IDX = 12'hf88;
    localparam logic [11:0] MASK_IDX = 12'hf89;
    localparam logic [11:0] LOCK_IDX = 12'hf8a;

    // Control register layout and values
    localparam logic [7:0] CTRL_RESET = 8'ha0;
    localparam logic [7:0] UNLOCK_KEY1 = 8'he7;
    localparam logic [7:0] UNLOCK_KEY2 = 8'h18;
    localparam int BIT_INT = 7;
    localparam int BIT_XTL = 6;
    localparam int BIT_WDT = 5;
    localparam int BIT_SOF = 4;
    localparam int BIT_WDF = 3;
    localparam int SEL_W = 3;

    // Event bits of the status and mask registers
    localparam int EV_W = 5;
    localparam int EV_UNLOCK = 0;
    localparam int EV_ACCEPT = 1;
    localparam int EV_REFUSE = 2;
    localparam int EV_SEQERR = 3;
    localparam int EV_HALT = 4;
    localparam logic [EV_W-1:0] STATUS_RESET = 5'h00;
    localparam logic [EV_W-1:0] MASK_RESET = 5'h00;

    // Unlock sequence; 2'b10 is illegal
    typedef enum logic [1:0] {
        LOCKED = 2'b00,
        KEY1_SEEN = 2'b01,
        UNLOCKED = 2'b11
    } lock_state_t;
endpackage
`default_nettype wire

/* src/oscillator_control_lock.sv */
// Design decision made here: the APB slave port.
`default_nettype none
module oscillator_control_lock
    import osc_ctrl_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic soft_reset_req,
    input wire logic gpio_a0_out,
    input wire logic gpio_a0_oe_n,
    input wire logic gpio_a1_out,
    input wire logic gpio_a1_oe_n,
    output logic port_a_pin_zero_out,
    output logic port_a_pin_zero_oe_n,
    output logic port_a_pin_zero_osc,
    output logic port_a_pin_one_out,
    output logic port_a_pin_one_oe_n,
    output logic port_a_pin_one_osc,
    output logic internal_osc_enable,
    output logic crystal_osc_enable,
    output logic watchdog_osc_enable,
    output logic sysclk_fail_detect_enable,
    output logic watchdog_fail_detect_enable,
    output logic [SEL_W-1:0] sysclk_source_select,
    output logic device_halt,
    output logic irq
);
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    lock_state_t lock_reg;
    lock_state_t lock_next;
    logic halt_reg;
    logic halt_next;
    logic [EV_W-1:0] status_reg;
    logic [EV_W-1:0] status_next;
    logic [EV_W-1:0] mask_reg;
    logic [EV_W-1:0] mask_next;
    logic [EV_W-1:0] fsm_ev;
    logic [EV_W-1:0] set_bits;
    logic [EV_W-1:0] clr_bits;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic irq_reg;
    logic irq_next;
    logic [11:0] idx;
    logic [7:0] wbyte;
    logic setup;
    logic access;
    logic wr;
    logic hit_ctrl;
    logic hit_status;
    logic hit_mask;
    logic hit_lock;
    logic mapped;
    logic ctrl_wr;
    logic accept;
    logic key2_hit;
    logic no_clock;

    // Bus phase and address decode
    assign idx = paddr[APB_ADDR_W-1:2];
    assign wbyte = pwdata[7:0];
    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign wr = access & pwrite & pstrb[0];
    assign hit_ctrl = (idx == CTRL_IDX);
    assign hit_status = (idx == STATUS_IDX);
    assign hit_mask = (idx == MASK_IDX);
    assign hit_lock = (idx == LOCK_IDX);
    assign mapped = hit_ctrl | hit_status | hit_mask | hit_lock;
    assign ctrl_wr = wr & hit_ctrl & ~soft_reset_req & ~halt_reg;
    assign accept = ctrl_wr & (lock_reg == UNLOCKED);
    assign key2_hit = ctrl_wr & (lock_reg == KEY1_SEEN) & (wbyte == UNLOCK_KEY2);

    // Zero-wait slave; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;
    assign prdata = prdata_reg;

    // Unlock sequence and control byte
    always_comb begin
        lock_next = lock_reg;
        ctrl_next = ctrl_reg;
        fsm_ev = '0;
        // A halted device ignores the other reset; only presetn revives it
        if (soft_reset_req && !halt_reg) begin
            lock_next = LOCKED;
            ctrl_next = CTRL_RESET;
        end else if (wr && hit_ctrl) begin
            if (halt_reg) begin
                // A halted device takes no further clock setting
                lock_next = LOCKED;
                fsm_ev[EV_REFUSE] = 1'b1;
            end else begin
                unique case (lock_reg)
                    LOCKED: begin
                        if (wbyte == UNLOCK_KEY1) begin
                            lock_next = KEY1_SEEN;
                        end else begin
                            fsm_ev[EV_REFUSE] = 1'b1;
                        end
                    end
                    KEY1_SEEN: begin
                        if (wbyte == UNLOCK_KEY2) begin
                            lock_next = UNLOCKED;
                            fsm_ev[EV_UNLOCK] = 1'b1;
                        end else if (wbyte == UNLOCK_KEY1) begin
                            lock_next = KEY1_SEEN;
                        end else begin
                            lock_next = LOCKED;
                            fsm_ev[EV_SEQERR] = 1'b1;
                        end
                    end
                    UNLOCKED: begin
                        ctrl_next = wbyte;
                        lock_next = LOCKED;
                        fsm_ev[EV_ACCEPT] = 1'b1;
                    end
                    default: begin
                        lock_next = LOCKED;
                    end
                endcase
            end
        end else if (access && pwrite && lock_reg == KEY1_SEEN) begin
            // Keys must be back to back; any other write breaks the pair
            lock_next = LOCKED;
            fsm_ev[EV_SEQERR] = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_reg <= LOCKED;
            ctrl_reg <= CTRL_RESET;
        end else begin
            lock_reg <= lock_next;
            ctrl_reg <= ctrl_next;
        end
    end

    // Halt latch; only the power-on reset on presetn clears it
    assign no_clock = ~ctrl_reg[BIT_SOF] & ~ctrl_reg[BIT_INT] & ~ctrl_reg[BIT_XTL] & ~ctrl_reg[BIT_WDT];

    always_comb begin
        halt_next = halt_reg | no_clock;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            halt_reg <= 1'b0;
        end else begin
            halt_reg <= halt_next;
        end
    end

    // Status, mask, interrupt and read data
    always_comb begin
        set_bits = fsm_ev;
        set_bits[EV_HALT] = halt_next & ~halt_reg;
        clr_bits = '0;
        // Clear only what the read returned, so a fresh event survives
        if (access && !pwrite && hit_status) begin
            clr_bits = prdata_reg[EV_W-1:0];
        end
        status_next = (status_reg & ~clr_bits) | set_bits;
        mask_next = mask_reg;
        if (wr && hit_mask) begin
            mask_next = wbyte[EV_W-1:0];
        end
        irq_next = |(status_next & mask_next);
        prdata_next = prdata_reg;
        if (setup) begin
            prdata_next = '0;
            if (hit_ctrl) begin
                prdata_next[7:0] = ctrl_reg;
            end else if (hit_status) begin
                prdata_next[EV_W-1:0] = status_reg;
            end else if (hit_mask) begin
                prdata_next[EV_W-1:0] = mask_reg;
            end else if (hit_lock) begin
                prdata_next[2:0] = {halt_reg, lock_reg};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= STATUS_RESET;
            mask_reg <= MASK_RESET;
            irq_reg <= 1'b0;
            prdata_reg <= '0;
        end else begin
            status_reg <= status_next;
            mask_reg <= mask_next;
            irq_reg <= irq_next;
            prdata_reg <= prdata_next;
        end
    end

    // Oscillator and clock-select outputs straight from the control flops
    assign internal_osc_enable = ctrl_reg[BIT_INT];
    assign crystal_osc_enable = ctrl_reg[BIT_XTL];
    assign watchdog_osc_enable = ctrl_reg[BIT_WDT];
    assign sysclk_fail_detect_enable = ctrl_reg[BIT_SOF];
    assign watchdog_fail_detect_enable = ctrl_reg[BIT_WDF];
    assign sysclk_source_select = ctrl_reg[SEL_W-1:0];
    assign device_halt = halt_reg;
    assign irq = irq_reg;

    // Crystal pin takeover, one arbiter per pin
    pin_owner u_pin_zero (
        .pclk(pclk),
        .presetn(presetn),
        .osc_claim(ctrl_reg[BIT_XTL]),
        .gpio_out(gpio_a0_out),
        .gpio_oe_n(gpio_a0_oe_n),
        .pin_out(port_a_pin_zero_out),
        .pin_oe_n(port_a_pin_zero_oe_n),
        .osc_owned(port_a_pin_zero_osc)
    );

    pin_owner u_pin_one (
        .pclk(pclk),
        .presetn(presetn),
        .osc_claim(ctrl_reg[BIT_XTL]),
        .gpio_out(gpio_a1_out),
        .gpio_oe_n(gpio_a1_oe_n),
        .pin_out(port_a_pin_one_out),
        .pin_oe_n(port_a_pin_one_oe_n),
        .osc_owned(port_a_pin_one_osc)
    );

    // Checks on the lock sequence and field effects
    a_unlock_needs_key2: assert property (
        @(posedge pclk) disable iff (!presetn)
        (lock_reg == UNLOCKED && $past(lock_reg) != UNLOCKED) |-> $past(key2_hit)
    ) else $error("unlocked without second key");

    a_relock_after_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        accept |=> (lock_reg == LOCKED) ##1 (ctrl_reg == $past(ctrl_reg))
    ) else $error("control register not relocked");

    a_internal_bit: assert property (
        @(posedge pclk) disable iff (!presetn)
        accept |=> internal_osc_enable == $past(pwdata[BIT_INT])
    ) else $error("internal oscillator bit wrong");

    a_crystal_takes_pins: assert property (
        @(posedge pclk) disable iff (!presetn)
        crystal_osc_enable |=> port_a_pin_zero_oe_n && port_a_pin_one_oe_n && port_a_pin_zero_osc
    ) else $error("crystal did not claim pins");

    a_watchdog_bit: assert property (
        @(posedge pclk) disable iff (!presetn)
        accept |=> watchdog_osc_enable == $past(pwdata[BIT_WDT])
    ) else $error("watchdog oscillator bit wrong");

    a_sysfail_bit: assert property (
        @(posedge pclk) disable iff (!presetn)
        accept |=> sysclk_fail_detect_enable == $past(pwdata[BIT_SOF])
    ) else $error("system clock failure bit wrong");

    a_source_select: assert property (
        @(posedge pclk) disable iff (!presetn)
        accept |=> sysclk_source_select == $past(wbyte[SEL_W-1:0])
    ) else $error("clock source select wrong");

    a_halt_entry: assert property (
        @(posedge pclk) disable iff (!presetn)
        no_clock |=> device_halt [*3]
    ) else $error("halt not entered or not held");

    a_halt_sticky: assert property (
        @(posedge pclk) disable iff (!presetn)
        device_halt |=> device_halt && $stable(ctrl_reg)
    ) else $error("halt released or control changed");

    a_locked_write_dropped: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr && hit_ctrl && lock_reg != UNLOCKED && !soft_reset_req) |=> $stable(ctrl_reg)
    ) else $error("locked write changed control");

    a_bad_key_restart: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ctrl_wr && lock_reg == KEY1_SEEN && wbyte != UNLOCK_KEY1 && wbyte != UNLOCK_KEY2)
        |=> lock_reg == LOCKED && status_reg[EV_SEQERR]
    ) else $error("bad key did not restart sequence");

    a_watchdog_fail_bit: assert property (
        @(posedge pclk) disable iff (!presetn)
        accept |=> watchdog_fail_detect_enable == $past(pwdata[BIT_WDF])
    ) else $error("watchdog failure bit wrong");
endmodule
`default_nettype wire

/* src/pin_owner.sv */
`default_nettype none
module pin_owner
    import osc_ctrl_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic osc_claim,
    input wire logic gpio_out,
    input wire logic gpio_oe_n,
    output logic pin_out,
    output logic pin_oe_n,
    output logic osc_owned
);
    logic pin_out_next;
    logic pin_oe_n_next;
    logic osc_owned_next;

    // Oscillator use beats the GPIO settings; pad released to the crystal
    always_comb begin
        pin_out_next = gpio_out;
        pin_oe_n_next = gpio_oe_n;
        osc_owned_next = 1'b0;
        if (osc_claim) begin
            pin_out_next = 1'b0;
            pin_oe_n_next = 1'b1;
            osc_owned_next = 1'b1;
        end
    end

    // Registered so the pad never sees a decode glitch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out <= 1'b0;
            pin_oe_n <= 1'b1;
            osc_owned <= 1'b0;
        end else begin
            pin_out <= pin_out_next;
            pin_oe_n <= pin_oe_n_next;
            osc_owned <= osc_owned_next;
        end
    end
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import osc_ctrl_pkg::*;

    localparam logic [APB_ADDR_W-1:0] A_CTRL = {CTRL_IDX, 2'b00};
    localparam logic [APB_ADDR_W-1:0] A_STAT = {STATUS_IDX, 2'b00};
    localparam logic [APB_ADDR_W-1:0] A_MASK = {MASK_IDX, 2'b00};
    localparam logic [APB_ADDR_W-1:0] A_LOCK = {LOCK_IDX, 2'b00};

    logic pclk, presetn, psel, penable, pwrite, soft_reset_req;
    logic [APB_ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic pready, pslverr, err_bit, g0o, g0e, g1o, g1e;
    logic p0o, p0e, p0s, p1o, p1e, p1s;
    logic ien, xen, wen, sfen, wfen, halt, irq;
    logic [SEL_W-1:0] sel;
    logic [7:0] outs;
    int err_count = 0;
    int n_checks = 0;

    assign outs = {ien, xen, wen, sfen, wfen, sel};

    oscillator_control_lock i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .soft_reset_req(soft_reset_req),
        .gpio_a0_out(g0o), .gpio_a0_oe_n(g0e), .gpio_a1_out(g1o), .gpio_a1_oe_n(g1e),
        .port_a_pin_zero_out(p0o), .port_a_pin_zero_oe_n(p0e), .port_a_pin_zero_osc(p0s),
        .port_a_pin_one_out(p1o), .port_a_pin_one_oe_n(p1e), .port_a_pin_one_osc(p1s),
        .internal_osc_enable(ien), .crystal_osc_enable(xen), .watchdog_osc_enable(wen),
        .sysclk_fail_detect_enable(sfen), .watchdog_fail_detect_enable(wfen),
        .sysclk_source_select(sel), .device_halt(halt), .irq(irq)
    );

    // Free-running bus clock, 8 ns
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [APB_ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err_bit = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [APB_ADDR_W-1:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input logic [APB_ADDR_W-1:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task automatic unlock();
        wr(A_CTRL, {24'h0, UNLOCK_KEY1});
        wr(A_CTRL, {24'h0, UNLOCK_KEY2});
    endtask

    // Reset held five cycles; inputs released off the sampling edge
    task automatic do_reset();
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask

    task automatic summarize();
        $display("checks=%0d errors=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Watchdog: the whole sequence needs about 160 cycles
    initial begin
        #100us;
        err_count++;
        summarize();
    end

    initial begin
        {psel, penable, pwrite, soft_reset_req} = 4'h0;
        paddr = '0;
        pwdata = 32'h0;
        pstrb = 4'hf;
        // GPIO wishes differ from the released pad state, so a takeover shows
        {g0o, g0e, g1o, g1e} = 4'ha;
        presetn = 1'b0;
        do_reset();
        // Reset values at register and at the enable outputs
        rdc(A_CTRL, 32'ha0);
        chk(outs, 8'ha0);
        chk(p0s, 1'b0);
        // Locked write is dropped and raises the interrupt
        wr(A_MASK, 32'h1f);
        rdc(A_MASK, 32'h1f);
        wr(A_CTRL, 32'h0);
        rdc(A_CTRL, 32'ha0);
        chk(irq, 1'b1);
        rdc(A_STAT, 32'h04);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b0);
        // Masked event leaves irq low but status sticky
        wr(A_MASK, 32'h0);
        wr(A_CTRL, 32'h0);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b0);
        rdc(A_STAT, 32'h04);
        // Write with byte strobe off is ignored
        pstrb <= 4'he;
        wr(A_MASK, 32'h1f);
        pstrb <= 4'hf;
        rdc(A_MASK, 32'h0);
        // Full unlock, one accepted write with crystal on
        wr(A_CTRL, {24'h0, UNLOCK_KEY1});
        rdc(A_LOCK, 32'h1);
        wr(A_CTRL, {24'h0, UNLOCK_KEY2});
        rdc(A_LOCK, 32'h3);
        wr(A_CTRL, 32'hd3);
        repeat (2) @(posedge pclk);
        rdc(A_CTRL, 32'hd3);
        chk(outs, 8'hd3);
        chk({p0o, p0e, p0s, p1o, p1e, p1s}, 6'b011011);
        apb(1'b0, A_STAT, 32'h0);
        chk(rd & 32'h3, 32'h3);
        // Second write without a new sequence is dropped
        rdc(A_LOCK, 32'h0);
        wr(A_CTRL, 32'ha0);
        rdc(A_CTRL, 32'hd3);
        // Bad second key restarts; following bytes are refused
        wr(A_CTRL, {24'h0, UNLOCK_KEY1});
        wr(A_CTRL, {24'h0, UNLOCK_KEY1});
        rdc(A_LOCK, 32'h1);
        wr(A_CTRL, 32'h55);
        rdc(A_LOCK, 32'h0);
        wr(A_CTRL, {24'h0, UNLOCK_KEY2});
        wr(A_CTRL, 32'ha0);
        rdc(A_CTRL, 32'hd3);
        apb(1'b0, A_STAT, 32'h0);
        chk(rd & 32'h8, 32'h8);
        // Crystal off hands the pins back to GPIO
        unlock();
        wr(A_CTRL, 32'had);
        repeat (2) @(posedge pclk);
        chk(outs, 8'had);
        chk({p0o, p0e, p0s, p1o, p1e, p1s}, 6'b100100);
        // Other reset restores defaults
        soft_reset_req <= 1'b1;
        @(posedge pclk);
        soft_reset_req <= 1'b0;
        rdc(A_CTRL, 32'ha0);
        // Unmapped index answers with an error
        apb(1'b0, 14'h0000, 32'h0);
        chk(err_bit, 1'b1);
        chk(rd, 32'h0);
        // All sources and system clock failure detection off: halt until power-on reset
        unlock();
        wr(A_CTRL, 32'h0b);
        repeat (2) @(posedge pclk);
        chk(halt, 1'b1);
        soft_reset_req <= 1'b1;
        @(posedge pclk);
        soft_reset_req <= 1'b0;
        repeat (2) @(posedge pclk);
        chk(halt, 1'b1);
        rdc(A_CTRL, 32'h0b);
        unlock();
        wr(A_CTRL, 32'ha0);
        rdc(A_LOCK, 32'h4);
        chk(halt, 1'b1);
        do_reset();
        chk(halt, 1'b0);
        rdc(A_CTRL, 32'ha0);
        summarize();
    end
endmodule
`default_nettype wire
